// [verilog/vsap_pkg.sv]
// Shared constants, carrier types and helper functions of the voice serial audio port.
package vsap_pkg;

  localparam int                 CLK_HZ     = 32'h0131_2d00; // System clock rate in Hz (20 MHz).
  localparam int                 SAMPLE_W   = 16;            // Width of one voice sample.
  localparam int                 ACC_W      = 24;            // Width of the bit clock phase accumulator.
  localparam int                 POS_W      = 6;             // Width of the bit position in a frame.
  localparam logic [POS_W-1:0]   NORM_FRAME = 6'h20;         // Normal framing: 16 bits times 2 timeslots.
  localparam logic [POS_W-1:0]   SLOT_LEN   = 6'h10;         // Data bits in one timeslot or PCM frame.
  localparam logic [POS_W-1:0]   SYNC_ONE   = 6'h01;         // One-bit PCM sync, or one-bit MSB delay.
  localparam logic [POS_W-1:0]   SYNC_TWO   = 6'h02;         // Two-bit PCM sync.
  localparam logic [POS_W-1:0]   POS_ZERO   = 6'h00;         // First position of a frame.
  localparam logic [3:0]         IDX_MSB    = 4'hf;          // Bit number of the sample MSB.
  localparam logic [9:0]         HOLD_MAX   = 10'h3ff;       // Hold count after which the link leaves reset.

  // Framing selection.
  typedef enum logic {VSAP_PCM, VSAP_NORMAL} vsap_framing_t;

  // Word sample rate selection.
  typedef enum logic [3:0] {
    VSAP_R8K, VSAP_R11K, VSAP_R12K, VSAP_R16K, VSAP_R22K, VSAP_R24K, VSAP_R32K, VSAP_R44K, VSAP_R48K
  } vsap_rate_t;

  // Port configuration as set by the serial audio configuration command.
  typedef struct packed {
    logic          master;     // High: port makes bit clock and word alignment.
    vsap_framing_t framing;    // PCM short alignment or normal long alignment.
    logic          sync2;      // PCM: strobe high for two bit clocks instead of one.
    logic          tx_fall;    // Normal: launch transmit bits on the falling edge.
    logic          msb_delay;  // Normal: MSB one bit clock after the strobe edge.
    vsap_rate_t    rate;       // Word sample rate.
  } vsap_cfg_t;

  // Path selection as set by the audio path command.
  typedef struct packed {
    logic ul_digital;  // Uplink takes the serial receive input.
    logic dl_digital;  // Downlink drives the serial transmit output.
  } vsap_path_t;

  // Position of a received data bit inside its sample.
  typedef struct packed {
    logic       valid;  // This frame position carries a received data bit.
    logic [3:0] idx;    // Bit number counted from the MSB.
  } vsap_slot_t;

  // Bit clocks in one frame for the given configuration.
  function automatic logic [POS_W-1:0] vsap_frame_len(input vsap_cfg_t c);
    if (c.framing == VSAP_NORMAL) begin
      return NORM_FRAME;
    end
    return SLOT_LEN + (c.sync2 ? SYNC_TWO : SYNC_ONE);
  endfunction : vsap_frame_len

  // Frame position that carries the sample MSB.
  function automatic logic [POS_W-1:0] vsap_first(input vsap_cfg_t c);
    if (c.framing == VSAP_PCM) begin
      return c.sync2 ? SYNC_TWO : SYNC_ONE;
    end
    return c.msb_delay ? SYNC_ONE : POS_ZERO;
  endfunction : vsap_first

  // Received data bit for a position; normal framing reads only the strobe-high slot.
  function automatic vsap_slot_t vsap_rx_slot(input vsap_cfg_t c, input logic [POS_W-1:0] p);
    logic [POS_W-1:0] rel;
    rel = p - vsap_first(c);
    vsap_rx_slot.valid = (p >= vsap_first(c)) && (rel < SLOT_LEN);
    vsap_rx_slot.idx   = rel[3:0];
  endfunction : vsap_rx_slot

  // Accumulator step per clock for two half bit clocks per frame bit.
  function automatic logic [ACC_W-1:0] vsap_half_step(input vsap_rate_t r);
    longint hz;
    unique case (r)
      VSAP_R8K:  hz = 8000;
      VSAP_R11K: hz = 11025;
      VSAP_R12K: hz = 12000;
      VSAP_R16K: hz = 16000;
      VSAP_R22K: hz = 22050;
      VSAP_R24K: hz = 24000;
      VSAP_R32K: hz = 32000;
      VSAP_R44K: hz = 44100;
      default:   hz = 48000;
    endcase
    return ACC_W'((hz << (ACC_W + 1)) / longint'(CLK_HZ));
  endfunction : vsap_half_step

  // Saturating sum of two samples.
  function automatic logic [SAMPLE_W-1:0] vsap_sat_add(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
    logic [SAMPLE_W:0] s;
    s = {a[SAMPLE_W-1], a} + {b[SAMPLE_W-1], b};
    if (s[SAMPLE_W] != s[SAMPLE_W-1]) begin
      return s[SAMPLE_W] ? {1'b1, {(SAMPLE_W-1){1'b0}}} : {1'b0, {(SAMPLE_W-1){1'b1}}};
    end
    return s[SAMPLE_W-1:0];
  endfunction : vsap_sat_add

  // System clock side state.
  typedef struct packed {
    vsap_cfg_t           cfg;       // Configuration in force.
    logic [9:0]          hold_cnt;  // Cycles since the last restart of the link.
    logic                hold;      // Link held in reset.
    logic [ACC_W-1:0]    acc;       // Bit clock phase accumulator.
    logic                sclk;      // Bit clock driven in master mode.
    logic                dl_req;    // Toggle: a new downlink word waits.
    logic [SAMPLE_W-1:0] dl_word;   // Downlink word handed to the link.
    logic                ack_s1;    // Synchroniser stage 1 of the link acknowledge.
    logic                ack_s2;    // Synchroniser stage 2 of the link acknowledge.
    logic                rxt_s1;    // Synchroniser stage 1 of the receive toggle.
    logic                rxt_s2;    // Synchroniser stage 2 of the receive toggle.
    logic                rxt_s3;    // Previous stage 2, for edge detection.
    logic [SAMPLE_W-1:0] ul_word;   // Last received uplink sample.
    logic                ul_valid;  // One-cycle pulse: new uplink sample.
    logic                bypass;    // Digital path selected, analog gains unused.
  } vsap_sys_t;

  // Link clock side state.
  typedef struct packed {
    logic                rst_s1;   // Synchroniser stage 1 of the link reset.
    logic                rst_s2;   // Synchroniser stage 2, the link reset itself.
    logic                req_s1;   // Synchroniser stage 1 of the downlink request.
    logic                req_s2;   // Synchroniser stage 2 of the downlink request.
    logic                ack;      // Toggle: downlink word taken.
    vsap_cfg_t           cfg;      // Configuration captured during reset.
    logic [POS_W-1:0]    pos;      // Frame position of the bit now on the wire.
    logic                wa_prev;  // Strobe seen at the previous rising edge.
    logic                wa_out;   // Strobe driven in master mode.
    logic                tx_bit;   // Transmit bit launched on the rising edge.
    logic [SAMPLE_W-1:0] tx_word;  // Sample being transmitted.
    logic [SAMPLE_W-1:0] rx_sh;    // Receive shift register.
    logic [SAMPLE_W-1:0] rx_word;  // Last complete received sample.
    logic                rx_tgl;   // Toggle: a received sample is complete.
  } vsap_lnk_t;

endpackage : vsap_pkg

// [verilog/vsap_port.sv]
// Voice serial audio port: bit clock maker, framing engine and sample crossings.
// The whole framing engine runs on the bit clock as seen on the wire, which is
// the clock this block drives in master mode and the codec's clock in slave mode.
`timescale 1ns/100ps
module vsap_port
  import vsap_pkg::*;
#(
  parameter bit MASTER_ONLY = 1'b0  // Reduced build variant.
) (
  input  wire logic                i_clk,           // System clock, 20 MHz.
  input  wire logic                i_srst,          // Synchronous reset, active high.
  input  wire vsap_cfg_t           i_cfg,           // Serial audio configuration.
  input  wire vsap_path_t          i_path,          // Uplink and downlink path selection.
  input  wire logic [SAMPLE_W-1:0] i_dl_sample,     // Downlink sample to transmit.
  input  wire logic                i_dl_valid,      // Downlink sample offered.
  output logic                     o_dl_ready,      // Downlink sample accepted this cycle.
  input  wire logic [SAMPLE_W-1:0] i_tone_sample,   // Ringer or service tone sample.
  input  wire logic                i_tone_active,   // A tone is playing.
  output logic [SAMPLE_W-1:0]      o_ul_sample,     // Received uplink sample.
  output logic                     o_ul_valid,      // Pulse: new uplink sample.
  output logic                     o_analog_bypass, // Analog gains unused.
  input  wire logic                i_sclk,          // Bit clock as seen on the wire.
  output logic                     o_sclk_o,        // Bit clock driven in master mode.
  output logic                     o_sclk_oe,       // Bit clock pin driven.
  input  wire logic                i_wa_i,          // Word alignment strobe pin level.
  output logic                     o_wa_o,          // Word alignment strobe driven.
  output logic                     o_wa_oe,         // Word alignment strobe pin driven.
  input  wire logic                i_sdin,          // Serial data input.
  output logic                     o_sdout          // Serial data output.
);

  vsap_sys_t  s_r;        // System side state.
  vsap_sys_t  s_nxt;      // Its next value.
  vsap_lnk_t  l_r;        // Link side state.
  vsap_lnk_t  l_nxt;      // Its next value.
  vsap_cfg_t  cfg_eff;    // Configuration after build limits.
  logic       active;     // Both paths digital.
  logic       rx_neg_r;   // Data input caught on the falling edge.
  logic       tx_neg_r;   // Transmit bit relaunched on the falling edge.

  // Configuration after build limits: the reduced build is master at 8 kHz.
  always_comb begin
    cfg_eff = i_cfg;
    if (MASTER_ONLY) begin
      cfg_eff.master = 1'b1;
      cfg_eff.rate   = VSAP_R8K;
    end
  end

  assign active = i_path.ul_digital && i_path.dl_digital;

  // System side next state: clock maker, link hold and sample hand-overs.
  always_comb begin
    logic [ACC_W:0] sum;
    logic           restart;
    sum     = '0;
    restart = 1'b0;
    s_nxt   = s_r;
    // Restart the link whenever the port is idle or its configuration moves.
    restart      = !active || (cfg_eff != s_r.cfg);
    s_nxt.cfg    = cfg_eff;
    s_nxt.bypass = active;
    if (restart) begin
      s_nxt.hold_cnt = '0;
      s_nxt.hold     = 1'b1;
    end else if (s_r.hold_cnt != HOLD_MAX) begin
      s_nxt.hold_cnt = s_r.hold_cnt + 10'h001;
    end else begin
      s_nxt.hold = 1'b0;
    end
    // Bit clock maker: one toggle per accumulator carry gives frame length times rate.
    if (s_r.cfg.master) begin
      sum = {1'b0, s_r.acc} + {1'b0, ACC_W'(vsap_half_step(s_r.cfg.rate) * vsap_frame_len(s_r.cfg))};
      s_nxt.acc = sum[ACC_W-1:0];
      if (sum[ACC_W]) begin
        s_nxt.sclk = ~s_r.sclk;
      end
    end else begin
      s_nxt.acc  = '0;
      s_nxt.sclk = 1'b0;
    end
    // Downlink hand-over: the word is held until the link acknowledges it.
    s_nxt.ack_s1 = l_r.ack;
    s_nxt.ack_s2 = s_r.ack_s1;
    if (i_dl_valid && o_dl_ready) begin
      s_nxt.dl_req  = ~s_r.dl_req;
      s_nxt.dl_word = i_tone_active ? vsap_sat_add(i_dl_sample, i_tone_sample) : i_dl_sample;
    end
    // Uplink hand-over: a toggle from the link marks a new complete word.
    s_nxt.rxt_s1   = l_r.rx_tgl;
    s_nxt.rxt_s2   = s_r.rxt_s1;
    s_nxt.rxt_s3   = s_r.rxt_s2;
    s_nxt.ul_valid = s_r.rxt_s2 != s_r.rxt_s3;
    if (s_r.rxt_s2 != s_r.rxt_s3) begin
      s_nxt.ul_word = l_r.rx_word;
    end
    if (i_srst) begin
      s_nxt          = '0;
      s_nxt.hold     = 1'b1;
      s_nxt.cfg      = cfg_eff;
      s_nxt.ack_s1   = l_r.ack;
      s_nxt.rxt_s1   = l_r.rx_tgl;
    end
  end

  // System side register.
  always_ff @(posedge i_clk) begin
    s_r <= s_nxt;
  end

  assign o_dl_ready      = (s_r.dl_req == s_r.ack_s2) && !i_srst;
  assign o_ul_sample     = s_r.ul_word;
  assign o_ul_valid      = s_r.ul_valid;
  assign o_analog_bypass = s_r.bypass;
  assign o_sclk_o        = s_r.sclk;
  assign o_sclk_oe       = s_r.cfg.master;

  // Link side next state: frame position, strobe, transmit and receive shifting.
  always_comb begin
    logic [POS_W-1:0] flen;
    logic [POS_W-1:0] done;
    logic [POS_W-1:0] pnx;
    logic [POS_W-1:0] rel;
    logic             rx_bit;
    logic             wa_rise;
    vsap_slot_t       slot;
    l_nxt   = l_r;
    flen    = vsap_frame_len(l_r.cfg);
    wa_rise = i_wa_i && !l_r.wa_prev;
    // Slave: a strobe rise marks the slot that just ended as frame position zero.
    done    = (!l_r.cfg.master && wa_rise) ? POS_ZERO : l_r.pos;
    pnx     = (done == flen - SYNC_ONE) ? POS_ZERO : done + SYNC_ONE;
    rel     = pnx - vsap_first(l_r.cfg);
    slot    = vsap_rx_slot(l_r.cfg, done);
    // PCM and falling-edge launch read on the rising edge; otherwise on the falling edge.
    rx_bit  = (l_r.cfg.framing == VSAP_PCM || l_r.cfg.tx_fall) ? i_sdin : rx_neg_r;
    l_nxt.rst_s1  = s_r.hold;
    l_nxt.rst_s2  = l_r.rst_s1;
    l_nxt.req_s1  = s_r.dl_req;
    l_nxt.req_s2  = l_r.req_s1;
    l_nxt.wa_prev = i_wa_i;
    l_nxt.pos     = pnx;
    // Receive: MSB first, complete word handed over by toggling.
    if (slot.valid) begin
      l_nxt.rx_sh = {l_r.rx_sh[SAMPLE_W-2:0], rx_bit};
      if (slot.idx == IDX_MSB) begin
        l_nxt.rx_word = {l_r.rx_sh[SAMPLE_W-2:0], rx_bit};
        l_nxt.rx_tgl  = ~l_r.rx_tgl;
      end
    end
    // A waiting downlink word is taken at the start of a frame.
    if (pnx == POS_ZERO && l_r.req_s2 != l_r.ack) begin
      l_nxt.tx_word = s_r.dl_word;
      l_nxt.ack     = l_r.req_s2;
    end
    // Strobe and transmit bit for the next frame position.
    if (l_r.cfg.framing == VSAP_PCM) begin
      l_nxt.wa_out = pnx < vsap_first(l_r.cfg);
      if (pnx == POS_ZERO) begin
        l_nxt.tx_bit = 1'b0;
      end else if (pnx < vsap_first(l_r.cfg)) begin
        l_nxt.tx_bit = l_nxt.tx_word[IDX_MSB];
      end else begin
        l_nxt.tx_bit = l_nxt.tx_word[IDX_MSB - rel[3:0]];
      end
    end else begin
      l_nxt.wa_out = pnx < SLOT_LEN;
      l_nxt.tx_bit = l_nxt.tx_word[IDX_MSB - rel[3:0]];
    end
    if (l_r.rst_s2) begin
      l_nxt.cfg     = s_r.cfg;
      l_nxt.pos     = vsap_frame_len(s_r.cfg) - SYNC_ONE;
      l_nxt.ack     = 1'b0;
      l_nxt.wa_out  = 1'b0;
      l_nxt.tx_bit  = 1'b0;
      l_nxt.tx_word = '0;
      l_nxt.rx_sh   = '0;
      l_nxt.rx_word = '0;
      l_nxt.rx_tgl  = 1'b0;
    end
  end

  // Link side register on the rising bit clock edge.
  always_ff @(posedge i_sclk) begin
    l_r <= l_nxt;
  end

  // Falling edge capture of the data input and relaunch of the transmit bit.
  always_ff @(negedge i_sclk) begin
    rx_neg_r <= i_sdin;
    tx_neg_r <= l_r.tx_bit;
  end

  assign o_sdout = (l_r.cfg.framing == VSAP_NORMAL && l_r.cfg.tx_fall) ? tx_neg_r : l_r.tx_bit;
  assign o_wa_o  = l_r.wa_out;
  assign o_wa_oe = l_r.cfg.master && !l_r.rst_s2;

  // Checks on the system clock side.
  a_bypass_follows: assert property (@(posedge i_clk) disable iff (i_srst)
    ##1 (o_analog_bypass == $past(active))) else $error("Analog bypass does not follow path selection.");
  a_idle_holds: assert property (@(posedge i_clk) disable iff (i_srst)
    !active |=> s_r.hold ##1 s_r.hold) else $error("Link not held while a path is analog.");
  a_tone_mixed: assert property (@(posedge i_clk) disable iff (i_srst)
    (i_dl_valid && o_dl_ready && i_tone_active) |=>
    (s_r.dl_word == vsap_sat_add($past(i_dl_sample), $past(i_tone_sample))))
    else $error("Tone not mixed into the downlink word.");
  a_ul_one_pulse: assert property (@(posedge i_clk) disable iff (i_srst)
    o_ul_valid |=> !o_ul_valid) else $error("Uplink valid longer than one cycle.");
  a_reduced_master: assert property (@(posedge i_clk) disable iff (i_srst)
    MASTER_ONLY |-> s_r.cfg.master && s_r.cfg.rate == VSAP_R8K) else $error("Reduced build left master 8 kHz.");
  // The clock flop may still hold a high level in the one cycle in which the configuration turns slave.
  a_slave_no_clk: assert property (@(posedge i_clk) disable iff (i_srst)
    (!s_r.cfg.master && !$past(s_r.cfg.master)) |-> !o_sclk_oe && !o_sclk_o)
    else $error("Bit clock driven in slave mode.");

  // Checks on the link clock side.
  a_pos_in_frame: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    l_r.pos < vsap_frame_len(l_r.cfg)) else $error("Frame position past frame length.");
  a_pcm_sync_low: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    (l_r.cfg.framing == VSAP_PCM && l_r.pos == POS_ZERO) |-> !l_r.tx_bit)
    else $error("First sync bit not low.");
  a_pcm_msb_twice: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    (l_r.cfg.framing == VSAP_PCM && l_r.cfg.sync2 && l_r.pos == SYNC_ONE) |=> (l_r.tx_bit == $past(l_r.tx_bit)))
    else $error("MSB not sent twice with two-bit sync.");
  a_pcm_wa_width: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    (l_r.cfg.master && l_r.cfg.framing == VSAP_PCM && $rose(l_r.wa_out)) |->
    ##1 (l_r.wa_out == l_r.cfg.sync2) ##1 !l_r.wa_out [*8] ##1 !l_r.wa_out [*7]
    ##1 (l_r.wa_out != l_r.cfg.sync2))
    else $error("PCM strobe width wrong.");
  a_norm_wa_half: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    (l_r.cfg.master && l_r.cfg.framing == VSAP_NORMAL) |-> (l_r.wa_out == (l_r.pos < SLOT_LEN)))
    else $error("Normal strobe not half a frame high.");
  a_pcm_msb_first: assert property (@(posedge i_sclk) disable iff (l_r.rst_s2)
    (l_r.cfg.framing == VSAP_PCM && l_r.pos == vsap_first(l_r.cfg)) |-> (l_r.tx_bit == l_r.tx_word[IDX_MSB]))
    else $error("PCM sample not MSB first.");

  c_pcm_frame: cover property (@(posedge i_sclk) l_r.cfg.framing == VSAP_PCM && $rose(l_r.wa_out));
  c_norm_rx: cover property (@(posedge i_sclk) l_r.cfg.framing == VSAP_NORMAL && $changed(l_r.rx_tgl));
  c_ul_word: cover property (@(posedge i_clk) o_ul_valid);
  c_dl_tone: cover property (@(posedge i_clk) i_dl_valid && o_dl_ready && i_tone_active);

endmodule : vsap_port

// [sim/vsap_codec.sv]
// Behavioural external codec: clock master when asked, frame tracker, data source and sink.
`timescale 1ns/100ps
module vsap_codec
  import vsap_pkg::*;
(
  input  wire logic                i_sclk,    // Resolved bit clock wire.
  input  wire logic                i_wa,      // Resolved strobe wire.
  input  wire logic                i_sdout,   // Port transmit data.
  input  wire logic                i_drv,     // Codec makes clock and strobe.
  input  wire vsap_cfg_t           i_cfg,     // Framing the codec expects.
  input  wire logic [SAMPLE_W-1:0] i_rx_word, // Sample sent into the port.
  output logic                     o_sclk,    // Codec bit clock.
  output logic                     o_wa,      // Codec strobe.
  output logic                     o_sdin,    // Data into the port.
  output logic [SAMPLE_W-1:0]      o_cap [2], // Words seen in each timeslot.
  output logic [1:0]               o_sync,    // First two bits after the strobe rise.
  output logic [POS_W-1:0]         o_hi_len,  // Last strobe high run in bit clocks.
  output logic [POS_W-1:0]         o_lo_len,  // Last strobe low run in bit clocks.
  output int                       o_frames,  // Strobe rises seen.
  output real                      o_period   // Time between the last two strobe rises.
);
  logic             pcm;                 // Short alignment framing.
  logic [POS_W-1:0] first, flen, hi, gn;  // First data bit, frame length, strobe width, next slot.
  logic [POS_W-1:0] pos = '0;             // Position tracked from the wire.
  logic [POS_W-1:0] gp = '0;              // Position of the strobe this model makes.
  logic [POS_W-1:0] run = '0;             // Bit clocks at the present strobe level.
  logic [POS_W-1:0] rel;                  // Position relative to the first data bit.
  logic             wa_prev = 1'b0;       // Strobe at the previous rising edge.
  real              t_rise = 0.0;         // Time of the previous strobe rise.
  assign pcm   = (i_cfg.framing == VSAP_PCM);
  assign first = pcm ? (i_cfg.sync2 ? 6'h02 : 6'h01) : (i_cfg.msb_delay ? 6'h01 : 6'h00);
  assign flen  = pcm ? 6'h10 + first : 6'h20;
  assign hi    = pcm ? first : 6'h10;
  assign gn    = (gp + 6'h01 >= flen) ? 6'h00 : gp + 6'h01;
  assign rel   = pos - first;
  // Bit sent at a position; bits outside the slot carry the inverted sample so a wrong slot shows.
  function automatic logic bit_at(input logic [POS_W-1:0] p);
    logic [POS_W-1:0] r;
    r = p - first;
    if (pcm ? (p >= first && r < 6'h10) : !r[4]) return i_rx_word[4'hf - r[3:0]];
    return ~i_rx_word[4'hf - r[3:0]];
  endfunction : bit_at
  initial begin
    o_sclk   = 1'b0;
    o_wa     = 1'b0;
    o_sdin   = 1'b0;
    o_frames = 0;
    o_period = 0.0;
  end
  // The clock runs only while the codec is master, and stands still otherwise.
  always #24 o_sclk = i_drv ? ~o_sclk : 1'b0;
  // The strobe changes on the falling edge so the port sees it settled at the rising edge.
  always @(negedge o_sclk) begin
    gp   <= gn;
    o_wa <= (gn < hi);
  end
  // Rising edge: frame position, strobe run lengths, frame period, normal mode data launch.
  // The position is that of the port's bit on the wire after this edge; a strobe rise seen here
  // means the slot that just ended was position zero.
  always @(posedge i_sclk) begin
    wa_prev <= i_wa;
    run     <= (i_wa != wa_prev) ? 6'h01 : run + 6'h01;
    if (i_wa != wa_prev && wa_prev) o_hi_len <= run;
    if (i_wa != wa_prev && !wa_prev) o_lo_len <= run;
    if (i_wa && !wa_prev) begin
      pos      <= 6'h01;
      o_frames <= o_frames + 1;
      o_period <= $realtime - t_rise;
      t_rise   <= $realtime;
      if (!pcm) o_sdin <= bit_at(6'h01);
    end else begin
      pos <= (pos + 6'h01 >= flen) ? 6'h00 : pos + 6'h01;
      if (!pcm) o_sdin <= bit_at((pos + 6'h01 >= flen) ? 6'h00 : pos + 6'h01);
    end
  end
  // Falling edge: PCM data launch for the position now on the wire, and capture of the port's bits.
  always @(negedge i_sclk) begin
    if (pcm) o_sdin <= bit_at(pos);
    if (pos == 6'h00) o_sync[0] <= i_sdout;
    if (pos == 6'h01) o_sync[1] <= i_sdout;
    if (!pcm || (pos >= first && rel < 6'h10)) o_cap[rel[4]][4'hf - rel[3:0]] <= i_sdout;
  end
endmodule : vsap_codec

// [sim/vsap_port_bench.sv]
// Self-checking bench of the voice serial audio port facing the codec model.
`timescale 1ns/100ps
module vsap_port_bench;
  import vsap_pkg::*;
  logic                clk = 1'b0, srst = 1'b1, drv = 1'b0;     // Clock, reset, codec is master.
  vsap_cfg_t           cfg = '0;                                // Port configuration.
  vsap_path_t          path = '0;                               // Path selection.
  logic [SAMPLE_W-1:0] dl_sample = '0, tone_sample = '0, rx_word = '0; // Stimulus words.
  logic                dl_valid = 1'b0, tone_active = 1'b0;    // Stimulus flags.
  logic [SAMPLE_W-1:0] ul_sample, cap [2];                      // Observed words.
  logic                dl_ready, ul_valid, bypass, sclk_o, sclk_oe, wa_o, wa_oe, sdout, c_sclk, c_wa, sdin;
  logic [1:0]          sync;                                    // Sync bits seen by the codec.
  logic [POS_W-1:0]    hi_len, lo_len;                          // Strobe run lengths.
  int                  frames, num_errors = 0, compares = 0;    // Frame and result counters.
  real                 period;                                  // Measured frame period in ns.
  wire                 sclk_w = sclk_oe ? sclk_o : (drv & c_sclk); // Bit clock wire, pulled low when free.
  wire                 wa_w = wa_oe ? wa_o : (drv & c_wa);      // Strobe wire, pulled low when free.
  always #25 clk = ~clk;
  vsap_port #(.MASTER_ONLY(1'b0)) uut (.i_clk(clk), .i_srst(srst), .i_cfg(cfg), .i_path(path),
    .i_dl_sample(dl_sample), .i_dl_valid(dl_valid), .o_dl_ready(dl_ready), .i_tone_sample(tone_sample),
    .i_tone_active(tone_active), .o_ul_sample(ul_sample), .o_ul_valid(ul_valid), .o_analog_bypass(bypass),
    .i_sclk(sclk_w), .o_sclk_o(sclk_o), .o_sclk_oe(sclk_oe), .i_wa_i(wa_w), .o_wa_o(wa_o), .o_wa_oe(wa_oe),
    .i_sdin(sdin), .o_sdout(sdout));
  vsap_codec codec (.i_sclk(sclk_w), .i_wa(wa_w), .i_sdout(sdout), .i_drv(drv), .i_cfg(cfg),
    .i_rx_word(rx_word), .o_sclk(c_sclk), .o_wa(c_wa), .o_sdin(sdin), .o_cap(cap), .o_sync(sync),
    .o_hi_len(hi_len), .o_lo_len(lo_len), .o_frames(frames), .o_period(period));
  // Prints the verdict and ends the run.
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop
  // Compares one value and reports a mismatch.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // Waits for a number of strobe rises under a bound.
  task automatic wait_frames(input int n);
    int target;
    target = frames + n;
    for (int k = 0; k < 12000 * n && frames < target; k++) @(posedge clk);
    check("frame count", 16'h1, 16'(frames >= target));
    if (frames < target) report_and_stop();
  endtask : wait_frames
  // Only the uplink is digital: the port stays idle and analog gains stay in use.
  task automatic idle_path();
    @(posedge clk);
    path <= 2'b10;
    repeat (1100) @(posedge clk);
    check("analog bypass", 16'h0, 16'(bypass));
    check("strobe enable", 16'h0, 16'(wa_oe));
  endtask : idle_path
  // One transfer in each direction with framing and strobe shape checked, and the frame period checked in master mode.
  task automatic run_case(input vsap_cfg_t c, input logic m, input logic [15:0] dl, input logic [15:0] tone,
                          input logic [15:0] rx, input logic [15:0] exp, input real per);
    int k;
    @(posedge clk);
    cfg <= c;
    drv <= ~m;
    path <= 2'b11;
    rx_word <= rx;
    tone_sample <= tone;
    tone_active <= (tone != 16'h0);
    repeat (1100) @(posedge clk);
    wait_frames(2);
    dl_sample <= dl;
    dl_valid <= 1'b1;
    k = 0;
    do begin @(posedge clk); k++; end while (dl_ready !== 1'b1 && k < 30000);
    dl_valid <= 1'b0;
    check("downlink taken", 16'h1, 16'(dl_ready));
    if (k >= 30000) report_and_stop();
    wait_frames(3);
    check("slot one word", exp, cap[0]);
    if (c.framing == VSAP_NORMAL) check("slot two word", exp, cap[1]);
    if (c.framing == VSAP_PCM) check("first sync bit", 16'h0, 16'(sync[0]));
    if (c.framing == VSAP_PCM && c.sync2) check("second sync bit", 16'(exp[15]), 16'(sync[1]));
    check("strobe high", (c.framing == VSAP_PCM) ? 16'(c.sync2 ? 2 : 1) : 16'h10, 16'(hi_len));
    check("strobe low", 16'h10, 16'(lo_len));
    if (m) check("frame period in range", 16'h1, 16'(period > per * 0.99 && period < per * 1.01));
    k = 0;
    do begin @(posedge clk); k++; end while (ul_valid !== 1'b1 && k < 30000);
    check("uplink valid", 16'h1, 16'(ul_valid));
    if (k >= 30000) report_and_stop();
    check("uplink word", rx, ul_sample);
    check("analog bypass", 16'h1, 16'(bypass));
  endtask : run_case
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    idle_path();
    run_case('{1'b1, VSAP_PCM, 1'b0, 1'b0, 1'b0, VSAP_R8K}, 1'b1, 16'h8001, 16'h0, 16'h5a3c, 16'h8001, 125000.0);
    run_case('{1'b1, VSAP_PCM, 1'b1, 1'b0, 1'b0, VSAP_R16K}, 1'b1, 16'h7000, 16'h2000, 16'hc3a5, 16'h7fff, 62500.0);
    run_case('{1'b0, VSAP_NORMAL, 1'b0, 1'b0, 1'b0, VSAP_R8K}, 1'b0, 16'h1234, 16'h0, 16'hbeef, 16'h1234, 0.0);
    run_case('{1'b1, VSAP_NORMAL, 1'b0, 1'b0, 1'b1, VSAP_R48K}, 1'b1, 16'hfedc, 16'h8000, 16'h0ff0, 16'h8000,
             20833.3);
    report_and_stop();
  end
endmodule : vsap_port_bench
